// file: hrc_capture.v
// Notes on behaviour
// - Each stored cycle holds pattern, time set, vector, cycle, expected, actual, fail and scan cycle.
// - In finite mode records cannot be fetched until the burst has ended.
// - In continuous mode records can be fetched while the burst runs.
// - A setup change, timing apply or unload, pattern unload or new burst drops all records.
// - Capture starts on first failure, a chosen label or a chosen cycle number.
// - Storage holds at most 8192 records, split evenly over the configured sites.
// - Settings are cycle selection, pretrigger count, max per site, finite flag and buffer size.
// - A channel shared by sites appears in the records of every site mapped to it.
// - A failure on a shared channel is flagged for every enabled site mapped to it.
// - A shared channel is active when any mapped site is enabled in the burst.
// - In continuous mode fetched records free room for new ones during the burst.
// - In continuous mode a full buffer raises overflow after the trigger, and records kept before it stay contiguous and ordered.
// - All logic runs from the single fixed 100 MHz master clock.
`timescale 1ns/10ps
`include "hrc_consts.vh"
module hrc_capture #(
  parameter NSITE = 8,                    // Number of sites, a power of two.
  parameter DEPTH = `HRC_DEPTH            // Total record slots.
) (
  input  wire                  fixed_master_clock, // 100 MHz master clock.
  input  wire                  resetn,       // Asynchronous reset, active low.
  input  wire                  clk_en,       // Freezes all state while low.
  input  wire [7:0]            reg_addr,     // Register byte address.
  input  wire [31:0]           reg_wdata,    // Register write data.
  input  wire                  reg_wr,       // Write strobe.
  input  wire                  reg_rd,       // Read strobe.
  output reg  [31:0]           reg_rdata,    // Read data, one cycle after the strobe.
  input  wire                  burst_start,  // Pulse, a new burst begins.
  input  wire                  burst_done,   // Pulse, the burst has ended.
  input  wire                  timing_apply, // Pulse, timing applied.
  input  wire                  timing_unload,// Pulse, time sets unloaded.
  input  wire                  pat_unload,   // Pulse, patterns unloaded.
  input  wire                  cyc_valid,    // One executed cycle this clock.
  input  wire [7:0]            pattern_id,   // Pattern identity.
  input  wire [4:0]            timeset_id,   // Time set identity.
  input  wire [31:0]           vector_num,   // Vector number.
  input  wire [31:0]           cycle_num,    // Cycle number.
  input  wire [15:0]           scan_num,     // Scan cycle number.
  input  wire [7:0]            label_id,     // Label of this vector.
  input  wire                  label_valid,  // Vector carries a label.
  input  wire [7:0]            exp_pins,     // Expected pin values.
  input  wire [7:0]            act_pins,     // Actual pin values.
  input  wire [7:0]            cmp_en,       // Channel compared this cycle.
  output reg  [7:0]            chan_active,  // Channel takes part in the burst.
  output reg  [NSITE-1:0]      site_fail,    // Site saw a failure in the previous cycle.
  output reg                   irq           // Level interrupt.
);
  localparam NCH = 8;
  localparam AW  = `HRC_AW;

  reg  [31:0]      ctrl_ff;
  reg  [13:0]      pretrig_ff;
  reg  [13:0]      maxrec_ff;
  reg  [13:0]      bufsize_ff;
  reg  [31:0]      trig_cycle_ff;
  reg  [7:0]       trig_label_ff;
  reg  [NSITE-1:0] site_en_ff;
  reg  [2:0]       status_ff;
  reg  [2:0]       mask_ff;
  reg  [7:0]       fetch_site_ff;
  reg  [NSITE-1:0] chmap_ff [0:NCH-1];
  reg              running_ff;
  reg              done_ff;
  reg              trig_ff;
  reg  [AW-1:0]    wp_ff [0:NSITE-1];
  reg  [AW-1:0]    rp_ff [0:NSITE-1];
  reg  [13:0]      cnt_ff [0:NSITE-1];
  reg  [116:0]     mem_ff [0:DEPTH-1];
  integer          i;

  wire [1:0]       tmode    = ctrl_ff[`HRC_CTRL_TMODE_HI:`HRC_CTRL_TMODE_LO];
  wire             failonly = ctrl_ff[`HRC_CTRL_FAILONLY];
  wire             finite   = ctrl_ff[`HRC_CTRL_FINITE];
  wire [1:0]       slog     = ctrl_ff[`HRC_CTRL_SLOG_HI:`HRC_CTRL_SLOG_LO];
  wire [13:0]      share    = 14'h2000 >> slog;
  wire [NCH-1:0]   ch_fail  = cmp_en & (exp_pins ^ act_pins);

  // Any event that makes the stored history stale empties every site.
  wire wr_cfg  = reg_wr && (reg_addr <= `HRC_SITE_EN || reg_addr >= `HRC_CHMAP0);
  wire clr_all = wr_cfg | timing_apply | timing_unload | pat_unload | burst_start;

  // Per-site masks, records, fail flags and fetch gating.
  wire [NSITE-1:0] site_hit;
  wire [NSITE-1:0] wr_en;
  wire [NSITE-1:0] pop;
  wire [NSITE-1:0] ovf_s;
  wire [116:0]     rec    [0:NSITE-1];
  wire [AW-1:0]    base   [0:NSITE-1];
  wire             any_fail = |site_hit;
  wire             trig_now = !trig_ff && running_ff && cyc_valid &&
                              ((tmode == `HRC_TRIG_FAIL && any_fail) ||
                               (tmode == `HRC_TRIG_LABEL_M && label_valid &&
                                label_id == trig_label_ff) ||
                               (tmode == `HRC_TRIG_CYCLE_M && cycle_num == trig_cycle_ff));
  wire             armed    = trig_ff | trig_now;
  wire [7:0]       fsel     = fetch_site_ff;
  wire             can_read = finite ? done_ff : 1'b1;
  wire             rd_pop   = reg_rd && reg_addr == `HRC_REC3 && can_read;

  genvar s;
  generate
    for (s = 0; s < NSITE; s = s + 1) begin : g_site
      wire [NCH-1:0] smask;
      genvar c;
      for (c = 0; c < NCH; c = c + 1) begin : g_ch
        assign smask[c] = chmap_ff[c][s];
      end
      // Site index at address width, so the base shift stays inside the store.
      localparam [AW-1:0] SIDX = s;
      wire live  = site_en_ff[s] && (s < (1 << slog)) && running_ff && cyc_valid;
      wire keep  = !failonly || (|(ch_fail & smask));
      wire full  = finite ? (cnt_ff[s] >= maxrec_ff || cnt_ff[s] >= share)
                          : (cnt_ff[s] >= bufsize_ff || cnt_ff[s] >= share);
      assign site_hit[s] = |(ch_fail & smask);
      assign pop[s]   = rd_pop && fsel == s && cnt_ff[s] != 14'h0000;
      // Pretrigger records need a nonzero pretrigger count; after the
      // trigger a full site stops (finite) or overflows (continuous).
      assign wr_en[s] = live && keep && (armed ? !full : (pretrig_ff != 14'h0000));
      assign ovf_s[s] = live && keep && armed && full && !finite;
      assign base[s]  = SIDX << (4'd13 - {2'b00, slog});
      assign rec[s]   = {pattern_id, timeset_id, scan_num, vector_num, cycle_num,
                         ch_fail & smask, act_pins & smask, exp_pins & smask};
    end
  endgenerate

  // Software settings and sticky status.
  always @(posedge fixed_master_clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff       <= `HRC_CTRL_RST;
      pretrig_ff    <= `HRC_PRETRIG_RST;
      maxrec_ff     <= `HRC_MAXREC_RST;
      bufsize_ff    <= `HRC_BUFSIZE_RST;
      trig_cycle_ff <= 32'h0000_0000;
      trig_label_ff <= 8'h00;
      site_en_ff    <= {NSITE{1'b0}};
      mask_ff       <= 3'h0;
      fetch_site_ff <= 8'h00;
      status_ff     <= 3'h0;
      for (i = 0; i < NCH; i = i + 1) chmap_ff[i] <= {NSITE{1'b0}};
    end else if (clk_en) begin
      if (reg_wr) begin
        case (reg_addr)
          `HRC_CTRL:       ctrl_ff       <= reg_wdata;
          `HRC_PRETRIG:    pretrig_ff    <= reg_wdata[13:0];
          `HRC_MAXREC:     maxrec_ff     <= reg_wdata[13:0];
          `HRC_BUFSIZE:    bufsize_ff    <= reg_wdata[13:0];
          `HRC_TRIG_CYCLE: trig_cycle_ff <= reg_wdata;
          `HRC_TRIG_LABEL: trig_label_ff <= reg_wdata[7:0];
          `HRC_SITE_EN:    site_en_ff    <= reg_wdata[NSITE-1:0];
          `HRC_IRQ_MASK:   mask_ff       <= reg_wdata[2:0];
          `HRC_FETCH_SITE: fetch_site_ff <= reg_wdata[7:0];
          default: begin
            for (i = 0; i < NCH; i = i + 1)
              if (reg_addr == `HRC_CHMAP0 + 4 * i) chmap_ff[i] <= reg_wdata[NSITE-1:0];
          end
        endcase
      end
      // A read clears the status, but an event in the same cycle survives.
      status_ff <= (status_ff & {3{!(reg_rd && reg_addr == `HRC_IRQ_STATUS)}}) |
                   {running_ff && burst_done, |ovf_s, trig_now};
    end
  end

  // Burst phase and trigger state; the trigger settings are sampled
  // live, so they must be stable before the burst is launched.
  always @(posedge fixed_master_clock or negedge resetn) begin
    if (!resetn) begin
      running_ff <= 1'b0;
      done_ff    <= 1'b0;
      trig_ff    <= 1'b0;
    end else if (clk_en) begin
      if (clr_all) begin
        trig_ff    <= 1'b0;
        done_ff    <= 1'b0;
        running_ff <= burst_start;
      end else begin
        if (trig_now) trig_ff <= 1'b1;
        if (burst_done && running_ff) begin
          running_ff <= 1'b0;
          done_ff    <= 1'b1;
        end
      end
    end
  end

  // Per-site circular buffers over one shared store.
  always @(posedge fixed_master_clock or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < NSITE; i = i + 1) begin
        wp_ff[i]  <= {AW{1'b0}};
        rp_ff[i]  <= {AW{1'b0}};
        cnt_ff[i] <= 14'h0000;
      end
    end else if (clk_en) begin
      for (i = 0; i < NSITE; i = i + 1) begin
        if (clr_all) begin
          wp_ff[i]  <= {AW{1'b0}};
          rp_ff[i]  <= {AW{1'b0}};
          cnt_ff[i] <= 14'h0000;
        end else begin
          if (wr_en[i])
            wp_ff[i] <= (wp_ff[i] == share - 14'h0001) ? {AW{1'b0}} : wp_ff[i] + 1'b1;
          if (wr_en[i] && !armed && cnt_ff[i] >= pretrig_ff) begin
            // Oldest pretrigger record is overwritten.
            rp_ff[i] <= (rp_ff[i] == share - 14'h0001) ? {AW{1'b0}} : rp_ff[i] + 1'b1;
          end else begin
            if (pop[i]) // Fetch frees a slot for streaming.
              rp_ff[i] <= (rp_ff[i] == share - 14'h0001) ? {AW{1'b0}} : rp_ff[i] + 1'b1;
            if (wr_en[i] && !pop[i])
              cnt_ff[i] <= cnt_ff[i] + 14'h0001;
            else if (pop[i] && !wr_en[i])
              cnt_ff[i] <= cnt_ff[i] - 14'h0001;
          end
        end
      end
    end
  end

  // Record store, flip-flops without reset.
  always @(posedge fixed_master_clock) begin
    if (clk_en) begin
      for (i = 0; i < NSITE; i = i + 1)
        if (wr_en[i] && !clr_all) mem_ff[base[i] + wp_ff[i]] <= rec[i];
    end
  end

  // Head record of the selected fetch site, blank while withheld.
  wire [7:0]   fs   = (fsel < NSITE) ? fsel : 8'h00;
  wire [116:0] head = (can_read && cnt_ff[fs[2:0]] != 14'h0000) ?
                      mem_ff[base[fs[2:0]] + rp_ff[fs[2:0]]] : 117'h0;
  reg  [31:0]  nxt_rdata;
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr)
      `HRC_CTRL:       nxt_rdata = ctrl_ff;
      `HRC_PRETRIG:    nxt_rdata = {18'h0_0000, pretrig_ff};
      `HRC_MAXREC:     nxt_rdata = {18'h0_0000, maxrec_ff};
      `HRC_BUFSIZE:    nxt_rdata = {18'h0_0000, bufsize_ff};
      `HRC_TRIG_CYCLE: nxt_rdata = trig_cycle_ff;
      `HRC_TRIG_LABEL: nxt_rdata = {24'h00_0000, trig_label_ff};
      `HRC_SITE_EN:    nxt_rdata = {{(32-NSITE){1'b0}}, site_en_ff};
      `HRC_IRQ_STATUS: nxt_rdata = {29'h0, status_ff};
      `HRC_IRQ_MASK:   nxt_rdata = {29'h0, mask_ff};
      `HRC_FETCH_SITE: nxt_rdata = {24'h00_0000, fetch_site_ff};
      `HRC_FETCH_INFO: nxt_rdata = {trig_ff, can_read, running_ff, 15'h0000, cnt_ff[fs[2:0]]};
      `HRC_REC0:       nxt_rdata = {head[116:109], 3'h0, head[108:104], head[103:88]};
      `HRC_REC1:       nxt_rdata = head[87:56];
      `HRC_REC2:       nxt_rdata = head[55:24];
      `HRC_REC3:       nxt_rdata = {8'h00, head[23:0]};
      default: begin
        for (i = 0; i < NCH; i = i + 1)
          if (reg_addr == `HRC_CHMAP0 + 4 * i) nxt_rdata = {{(32-NSITE){1'b0}}, chmap_ff[i]};
      end
    endcase
  end

  // Registered outputs: read data, channel activity, site fails, interrupt.
  reg [7:0] nxt_active;
  always @* begin
    for (i = 0; i < NCH; i = i + 1)
      nxt_active[i] = |(chmap_ff[i] & site_en_ff);
  end

  always @(posedge fixed_master_clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata   <= 32'h0000_0000;
      chan_active <= 8'h00;
      site_fail   <= {NSITE{1'b0}};
      irq         <= 1'b0;
    end else if (clk_en) begin
      reg_rdata   <= reg_rd ? nxt_rdata : 32'h0000_0000;
      chan_active <= nxt_active;
      site_fail   <= (running_ff && cyc_valid) ? (site_hit & site_en_ff) : {NSITE{1'b0}};
      irq         <= |(status_ff & mask_ff);
    end
  end
endmodule // hrc_capture

// file: hrc_consts.vh
`ifndef HRC_CONSTS_VH
`define HRC_CONSTS_VH
// Register byte offsets.
`define HRC_CTRL        8'h00
`define HRC_PRETRIG     8'h04
`define HRC_MAXREC      8'h08
`define HRC_BUFSIZE     8'h0C
`define HRC_TRIG_CYCLE  8'h10
`define HRC_TRIG_LABEL  8'h14
`define HRC_SITE_EN     8'h18
`define HRC_IRQ_STATUS  8'h1C
`define HRC_IRQ_MASK    8'h20
`define HRC_FETCH_SITE  8'h24
`define HRC_FETCH_INFO  8'h28
`define HRC_REC0        8'h2C
`define HRC_REC1        8'h30
`define HRC_REC2        8'h34
`define HRC_REC3        8'h38
`define HRC_CHMAP0      8'h40
// Control register fields.
`define HRC_CTRL_TMODE_LO 0
`define HRC_CTRL_TMODE_HI 1
`define HRC_CTRL_FAILONLY 2
`define HRC_CTRL_FINITE   3
`define HRC_CTRL_SLOG_LO  4
`define HRC_CTRL_SLOG_HI  5
// Reset values.
`define HRC_CTRL_RST     32'h0000_0008
`define HRC_PRETRIG_RST  14'h0000
`define HRC_MAXREC_RST   14'h0400
`define HRC_BUFSIZE_RST  14'h0400
// Trigger modes.
`define HRC_TRIG_FAIL    2'h0
`define HRC_TRIG_LABEL_M 2'h1
`define HRC_TRIG_CYCLE_M 2'h2
// Status bits.
`define HRC_ST_TRIG      0
`define HRC_ST_OVF       1
`define HRC_ST_DONE      2
// Capacity.
`define HRC_DEPTH        8192
`define HRC_AW           13
`endif

// file: hrc_capture_props.sv
`timescale 1ns/10ps
// Port-level checks of the capture block; record contents are judged by the bench.
module hrc_capture_chk #(
  parameter NSITE = 8                        // Number of sites.
) (
  input wire             fixed_master_clock, // Master clock.
  input wire             resetn,             // Reset, active low.
  input wire             clk_en,             // Run enable.
  input wire [7:0]       reg_addr,           // Register address.
  input wire [31:0]      reg_wdata,          // Write data.
  input wire             reg_wr,             // Write strobe.
  input wire             reg_rd,             // Read strobe.
  input wire [31:0]      reg_rdata,          // Read data.
  input wire             cyc_valid,          // Executed cycle.
  input wire [7:0]       exp_pins,           // Expected pins.
  input wire [7:0]       act_pins,           // Actual pins.
  input wire [7:0]       cmp_en,             // Compare enables.
  input wire [7:0]       chan_active,        // Active channels.
  input wire [NSITE-1:0] site_fail,          // Site failures.
  input wire             irq                 // Interrupt.
);
  default clocking @(posedge fixed_master_clock); endclocking
  default disable iff (!resetn);
  // Read data must stay zero unless a read was taken one cycle before.
  chk_rdata_idle: assert property (!(reg_rd && clk_en) |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside a read answer");
  chk_unmapped_read: assert property (reg_rd && clk_en && reg_addr == 8'h3C |=> reg_rdata == 0)
    else $error("unmapped read not zero");
  // A frozen clock enable must hold channel activity, site failures and the interrupt.
  chk_freeze_hold: assert property (!clk_en |=> $stable(chan_active) && $stable(site_fail)
    && $stable(irq)) else $error("outputs moved while frozen");
  chk_fail_cause: assert property (!cyc_valid && clk_en |=> site_fail == '0)
    else $error("site failure without a cycle");
  chk_fail_nocmp: assert property (cyc_valid && clk_en && ((exp_pins ^ act_pins) & cmp_en) == 0
    |=> site_fail == '0) else $error("site failure without a miscompare");
  // Clearing the mask must drop the interrupt after mask and output stages.
  chk_irq_masked: assert property (reg_wr && clk_en && reg_addr == 8'h20 && reg_wdata == 0
    |-> ##2 !irq) else $error("interrupt high with mask cleared");
  chk_chan_idle: assert property (reg_wr && clk_en && reg_addr == 8'h18 && reg_wdata == 0
    |-> ##2 chan_active == 8'h00) else $error("channel active with no site enabled");
  chk_site_quiet: assert property (reg_wr && clk_en && reg_addr == 8'h18 && reg_wdata == 0
    |-> ##2 (site_fail == '0) [*3]) else $error("disabled site reports failure");
endmodule // hrc_capture_chk
bind hrc_capture hrc_capture_chk #(.NSITE(NSITE)) u_chk (.*);

// file: hrc_host_model.sv
`timescale 1ns/10ps
// Host software side: single-cycle strobes, read answer taken one cycle later.
module hrc_host (
  input  wire        fixed_master_clock,  // Master clock.
  input  wire [31:0] reg_rdata,           // Read answer.
  output reg  [7:0]  reg_addr  = 8'h00,   // Register address.
  output reg  [31:0] reg_wdata = 32'h0,   // Write data.
  output reg         reg_wr    = 1'b0,    // Write strobe.
  output reg         reg_rd    = 1'b0     // Read strobe.
);
  // Setup is always written before a burst is launched by the bench.
  task put(input [7:0] a, input [31:0] d);
    begin
      @(posedge fixed_master_clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge fixed_master_clock);
      reg_wr <= 1'b0;
    end
  endtask
  // The answer stands one cycle only, so it is taken at the edge that ends it.
  task get(input [7:0] a, output [31:0] d);
    begin
      @(posedge fixed_master_clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge fixed_master_clock);
      reg_rd <= 1'b0;
      @(posedge fixed_master_clock);
      d = reg_rdata;
    end
  endtask
endmodule // hrc_host

// file: tb.sv
`timescale 1ns/10ps
// Bench for the history capture block: register tasks plus a cycle feeder.
module tb;
  localparam [31:0] ALL = 32'hFFFF_FFFF;
  localparam [31:0] CNT = 32'h0000_3FFF;
  reg         fixed_master_clock, resetn, clk_en, cyc_valid, label_valid;
  reg  [4:0]  ev;
  reg  [7:0]  label_id, act_pins;
  reg  [31:0] cycle_num;
  wire [7:0]  reg_addr, chan_active, site_fail;
  wire [31:0] reg_wdata, reg_rdata;
  wire        reg_wr, reg_rd, irq;
  integer     num_errors = 0, cmp_count = 0, tick = 0, n, k;
  hrc_capture dut (.*, .burst_start(ev[0]), .burst_done(ev[1]), .timing_apply(ev[2]),
    .timing_unload(ev[3]), .pat_unload(ev[4]), .pattern_id(8'h5A), .timeset_id(5'h03),
    .vector_num(cycle_num + 32'd100), .scan_num(cycle_num[15:0]), .exp_pins(8'h0F),
    .cmp_en(8'h01));
  hrc_host host (.*);
  task chkv(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [31:0] m);
    reg [31:0] d;
    begin
      host.get(a, d);
      chkv(d & m, e);
    end
  endtask
  // One-cycle event pulse: 0 start, 1 done, 2 apply, 3 unload timing, 4 unload patterns.
  task pul(input integer i);
    begin
      @(posedge fixed_master_clock);
      ev <= 5'h01 << i;
      @(posedge fixed_master_clock);
      ev <= 5'h00;
    end
  endtask
  // Feed one executed cycle; a miscompare on channel 0 comes from act_pins alone.
  task cy(input [31:0] c, input [7:0] a, input lv);
    begin
      @(posedge fixed_master_clock);
      cyc_valid   <= 1'b1;
      cycle_num   <= c;
      act_pins    <= a;
      label_valid <= lv;
      @(posedge fixed_master_clock);
      cyc_valid   <= 1'b0;
      label_valid <= 1'b0;
    end
  endtask
  // A record is four reads, and the last one pops it.
  task rec(input [31:0] c, input [7:0] f);
    begin
      rd(8'h2C, {8'h5A, 3'h0, 5'h03, c[15:0]}, ALL);
      rd(8'h30, c + 32'd100, ALL);
      rd(8'h34, c, ALL);
      // Pin fields carry only the channels mapped to the site, here channel 0.
      rd(8'h38, {8'h00, f, 8'h01 ^ f, 8'h01}, ALL);
    end
  endtask
  task give_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    fixed_master_clock = 1'b0;
    forever #5 fixed_master_clock = ~fixed_master_clock;
  end
  // The run needs well under a thousand cycles, so this only cuts a hang.
  always @(posedge fixed_master_clock) begin
    tick = tick + 1;
    if (tick == 5000) begin
      num_errors = num_errors + 1;
      give_verdict;
    end
  end
  initial begin
    {resetn, clk_en, cyc_valid, label_valid, ev} = 9'h080;
    {label_id, act_pins, cycle_num} = {8'h07, 8'h0F, 32'h0};
    repeat (6) @(posedge fixed_master_clock);
    resetn <= 1'b1;
    rd(8'h00, 32'h0000_0008, ALL);
    rd(8'h04, 32'h0000_0000, ALL);
    rd(8'h08, 32'h0000_0400, ALL);
    rd(8'h0C, 32'h0000_0400, ALL);
    rd(8'h3C, 32'h0000_0000, ALL);
    $display("test reset values done");
    // Finite, cycle 5 trigger, two sites sharing channel 0, three records at most.
    host.put(8'h00, 32'h0000_001A);
    host.put(8'h08, 32'h0000_0003);
    host.put(8'h10, 32'h0000_0005);
    host.put(8'h18, 32'h0000_0003);
    host.put(8'h40, 32'h0000_0003);
    host.put(8'h20, 32'h0000_0007);
    pul(0);
    #1 chkv(chan_active, 8'h01);
    for (n = 1; n <= 8; n = n + 1) begin
      cy(n, (n == 6) ? 8'h0E : 8'h0F, 1'b0);
      if (n == 6) #1 chkv(site_fail, 8'h03);
    end
    rd(8'h28, 32'h2000_0000, 32'h6000_0000);
    rd(8'h2C, 32'h0000_0000, ALL);
    pul(1);
    rd(8'h28, 32'hC000_0003, ALL);
    #1 chkv(irq, 1'b1);
    rec(5, 8'h00);
    rec(6, 8'h01);
    rec(7, 8'h00);
    rd(8'h1C, 32'h0000_0005, ALL);
    #1 chkv(irq, 1'b0);
    host.put(8'h24, 32'h0000_0001);
    rec(5, 8'h00);
    clk_en <= 1'b0;
    repeat (3) @(posedge fixed_master_clock);
    clk_en <= 1'b1;
    $display("test finite capture done");
    // Continuous, label trigger, two pretrigger records, room for four, then overflow.
    host.put(8'h20, 32'h0000_0000);
    host.put(8'h24, 32'h0000_0000);
    host.put(8'h04, 32'h0000_0002);
    host.put(8'h0C, 32'h0000_0004);
    host.put(8'h14, 32'h0000_0007);
    host.put(8'h00, 32'h0000_0011);
    pul(0);
    for (n = 1; n <= 9; n = n + 1) cy(n, (n == 6) ? 8'h0E : 8'h0F, n == 5);
    rd(8'h28, 32'hE000_0004, ALL);
    for (n = 3; n <= 6; n = n + 1) rec(n, (n == 6) ? 8'h01 : 8'h00);
    rd(8'h28, 32'h0000_0000, CNT);
    rd(8'h1C, 32'h0000_0003, ALL);
    chkv(irq, 1'b0);
    $display("test continuous capture done");
    // Every clearing event must drop the one record of a first-failure burst.
    host.put(8'h04, 32'h0000_0000);
    host.put(8'h00, 32'h0000_0018);
    for (k = 0; k <= 4; k = k + 1) begin
      pul(0);
      cy(1, 8'h0F, 1'b0);
      cy(2, 8'h0E, 1'b0);
      pul(1);
      rd(8'h28, 32'h0000_0001, CNT);
      if (k == 1) host.put(8'h04, 32'h0000_0000);
      else pul(k);
      rd(8'h28, 32'h0000_0000, CNT);
    end
    $display("test clearing events done");
    host.put(8'h18, 32'h0000_0000);
    pul(0);
    cy(1, 8'h0E, 1'b0);
    #1 chkv(site_fail, 32'h0000_0000);
    chkv(chan_active, 32'h0000_0000);
    $display("test disabled sites done");
    give_verdict;
  end
endmodule // tb
